// File: core/rtc_consts.vh
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// ==========================================================
// register indices, byte address is four times the index
`define IDX_SUBSEC 6'h00
`define IDX_SEC 6'h01
`define IDX_MIN 6'h02
`define IDX_HOUR 6'h03
`define IDX_DAY 6'h04
`define IDX_DATE 6'h05
`define IDX_MONTH 6'h06
`define IDX_YEAR 6'h07
`define IDX_CONTROL 6'h08
`define IDX_HALT 6'h0C
`define IDX_FLAGS 6'h0F
`define IDX_TAMPER1 6'h14
`define IDX_TAMPER2 6'h15
`define NUM_CLOCK_REGS 6'h08

// ==========================================================
// field positions
`define BIT_OSC_HALT 7
`define BIT_HALT_UPDATE 6
`define BIT_TAMPER_ARM 7
`define BIT_FLAG_TB1 1
`define BIT_FLAG_TB2 0

// ==========================================================
// bcd ranges and reset values
`define BCD_ZERO 8'h00
`define BCD_ONE 8'h01
`define BCD_MAX_SUBSEC 8'h99
`define BCD_MAX_SEC 8'h59
`define BCD_MAX_HOUR 8'h23
`define BCD_MAX_DOW 8'h07
`define BCD_MAX_MONTH 8'h12
`define BCD_MAX_YEAR 8'h99
`define BCD_FEB 5'h02
`define BCD_APR 5'h04
`define BCD_JUN 5'h06
`define BCD_SEP 5'h09
`define BCD_NOV 5'h11
`define BCD_DAYS_28 8'h28
`define BCD_DAYS_29 8'h29
`define BCD_DAYS_30 8'h30
`define BCD_DAYS_31 8'h31
`define BCD_NINE 4'h9

// ==========================================================
// timing
`define CLOCK_HZ 250000000
`define SUBSEC_HZ 100

// ==========================================================
// ahb encodings
`define HRESP_OKAY 1'b0

`endif

// File: core/rtc_user_timestamp.v
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rtc_consts.vh"
// Contract
// - tamper freezes user clock register copy
// - disarming clears flag and resumes copy
// - first tamper time kept, later ignored
// - armed tamper blocks power-down halt setting
// - clock register write zeroes sub-seconds
// - sub-second register ignores writes, zeroed by clock write and freeze
// - century bits at D6, D7 of 03h
// - weekday D0-D2 of 04h; date, month, year
// - eight clock bytes in BCD, ordered
// - 01h D7 stops and restarts oscillator
// - clock write loads counters, resets divider
// - clock bytes singly readable; control independent
// - copy suspended during access and backup
// - power-down sets halt-update bit
// - freeze zeroes 00h, keeps 01h-07h
// - internal counters keep running while frozen
// - clearing halt-update restarts the copy
// - flag sets only when channel armed
// - copy resumes on bus stop or pointer move off 00h-07h
module rtc_user_timestamp #(
  parameter TICK_CYCLES = `CLOCK_HZ / `SUBSEC_HZ
) (
  input wire clock,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [1:0] tamper_in,
  input wire power_down_in,
  input wire backup_in,
  output reg time_frozen,
  output reg osc_running
);

  // ==========================================================
  // bcd helpers
  // returns {carry, next} for a bcd field that wraps hi -> lo
  function [8:0] bcd_inc;
    input [7:0] val;
    input [7:0] lo;
    input [7:0] hi;
    begin
      if (val >= hi) begin
        bcd_inc = {1'b1, lo};
      end else if (val[3:0] == `BCD_NINE) begin
        bcd_inc = {1'b0, val[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {1'b0, val[7:4], val[3:0] + 4'h1};
      end
    end
  endfunction

  // last date of the month, leap years every fourth bcd year
  function [7:0] last_date;
    input [4:0] month;
    input [7:0] year;
    reg leap;
    begin
      leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                     : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
      if (month == `BCD_FEB) begin
        last_date = leap ? `BCD_DAYS_29 : `BCD_DAYS_28;
      end else if (month == `BCD_APR || month == `BCD_JUN ||
                   month == `BCD_SEP || month == `BCD_NOV) begin
        last_date = `BCD_DAYS_30;
      end else begin
        last_date = `BCD_DAYS_31;
      end
    end
  endfunction

  // ==========================================================
  // storage
  reg [7:0] user_q [0:7];
  reg [7:0] sys_q [0:7];
  reg [7:0] control_q, halt_reg_q, tamper1_q, tamper2_q;
  reg [1:0] tamper_event_flag_q;
  reg [31:0] div_q;
  reg wr_pend_q;
  reg [5:0] wr_idx_q;
  reg clock_access_q;
  reg [1:0] tamper_meta_q, tamper_sync_q;
  reg pd_meta_q, pd_sync_q, pd_prev_q;
  reg backup_meta_q, backup_sync_q;
  integer i;

  // ==========================================================
  // pin synchronisers, first stage feeds only the second
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tamper_meta_q <= 2'h0;
      tamper_sync_q <= 2'h0;
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
      pd_prev_q <= 1'b0;
      backup_meta_q <= 1'b0;
      backup_sync_q <= 1'b0;
    end else begin
      tamper_meta_q <= tamper_in;
      tamper_sync_q <= tamper_meta_q;
      pd_meta_q <= power_down_in;
      pd_sync_q <= pd_meta_q;
      pd_prev_q <= pd_sync_q;
      backup_meta_q <= backup_in;
      backup_sync_q <= backup_meta_q;
    end
  end

  // ==========================================================
  // bus decode
  wire addr_phase = hsel & hready & htrans[1];
  wire [5:0] addr_idx = haddr[7:2];
  wire addr_is_clock = addr_idx < `NUM_CLOCK_REGS;
  wire wr_clock = wr_pend_q & (wr_idx_q < `NUM_CLOCK_REGS);
  wire [7:0] wbyte = hwdata[7:0];
  wire [1:0] arms = {tamper1_q[`BIT_TAMPER_ARM], tamper2_q[`BIT_TAMPER_ARM]};
  wire arm_clear1 = wr_pend_q & (wr_idx_q == `IDX_TAMPER1) & ~wbyte[`BIT_TAMPER_ARM];
  wire arm_clear2 = wr_pend_q & (wr_idx_q == `IDX_TAMPER2) & ~wbyte[`BIT_TAMPER_ARM];

  // ==========================================================
  // freeze conditions
  wire [1:0] tamper_hit = tamper_sync_q & arms;
  wire tamper_freeze = |tamper_event_flag_q;
  wire pd_edge = pd_sync_q & ~pd_prev_q;
  wire ht_set = pd_edge & ~(|arms);
  wire ht_q = halt_reg_q[`BIT_HALT_UPDATE];
  // software may set the halt bit too; it must freeze the same way
  wire ht_sw_set = wr_pend_q & (wr_idx_q == `IDX_HALT) & wbyte[`BIT_HALT_UPDATE];
  // freeze starts: zero the sub-second byte once
  wire freeze_start = ((ht_set | ht_sw_set) & ~ht_q) | ((|tamper_hit) & ~tamper_freeze);
  wire transfer_en = ~clock_access_q & ~backup_sync_q & ~ht_q & ~tamper_freeze &
                     ~freeze_start;

  // ==========================================================
  // sub-second tick, divider stopped by the oscillator halt bit
  wire osc_halt = sys_q[1][`BIT_OSC_HALT];
  wire tick = ~osc_halt & (div_q == TICK_CYCLES - 1);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q <= 32'h0;
    end else if (wr_clock || osc_halt || tick) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // ==========================================================
  // internal counter increment, non-time bits ride along
  reg [7:0] t0, t1, t2, t3, t4, t5, t6, t7;
  reg [8:0] r;
  reg c;
  always @* begin
    t0 = sys_q[0];
    t1 = sys_q[1];
    t2 = sys_q[2];
    t3 = sys_q[3];
    t4 = sys_q[4];
    t5 = sys_q[5];
    t6 = sys_q[6];
    t7 = sys_q[7];
    r = 9'h0;
    c = tick;
    if (c) begin
      r = bcd_inc(t0, `BCD_ZERO, `BCD_MAX_SUBSEC);
      t0 = r[7:0];
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({1'b0, t1[6:0]}, `BCD_ZERO, `BCD_MAX_SEC);
      t1 = {t1[7], r[6:0]};
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({1'b0, t2[6:0]}, `BCD_ZERO, `BCD_MAX_SEC);
      t2 = {t2[7], r[6:0]};
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({2'b0, t3[5:0]}, `BCD_ZERO, `BCD_MAX_HOUR);
      t3 = {t3[7:6], r[5:0]};
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({5'b0, t4[2:0]}, `BCD_ONE, `BCD_MAX_DOW);
      t4 = {t4[7:3], r[2:0]};
      r = bcd_inc({2'b0, t5[5:0]}, `BCD_ONE, last_date(t6[4:0], t7));
      t5 = {t5[7:6], r[5:0]};
      c = r[8];
    end
    if (c) begin
      r = bcd_inc({3'b0, t6[4:0]}, `BCD_ONE, `BCD_MAX_MONTH);
      t6 = {t6[7:5], r[4:0]};
      c = r[8];
    end
    if (c) begin
      r = bcd_inc(t7, `BCD_ZERO, `BCD_MAX_YEAR);
      t7 = r[7:0];
      c = r[8];
    end
    // century pair lives in the top of the hours byte
    if (c) begin
      t3 = {t3[7:6] + 2'h1, t3[5:0]};
    end
  end

  // ==========================================================
  // clock bytes: user copy and system copy
  // a write is applied to the user byte, then loaded whole into the
  // counters; any non-time bit written here is stored with the byte and kept, and D7 of 01h stops the oscillator
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        user_q[i] <= (i > 3 && i < 7) ? `BCD_ONE : `BCD_ZERO;
        sys_q[i] <= (i > 3 && i < 7) ? `BCD_ONE : `BCD_ZERO;
      end
    end else if (wr_clock) begin
      for (i = 1; i < 8; i = i + 1) begin
        if (wr_idx_q == i[5:0]) begin
          user_q[i] <= wbyte;
          sys_q[i] <= wbyte;
        end else begin
          sys_q[i] <= user_q[i];
        end
      end
      user_q[0] <= `BCD_ZERO;
      sys_q[0] <= `BCD_ZERO;
    end else begin
      sys_q[0] <= t0;
      sys_q[1] <= t1;
      sys_q[2] <= t2;
      sys_q[3] <= t3;
      sys_q[4] <= t4;
      sys_q[5] <= t5;
      sys_q[6] <= t6;
      sys_q[7] <= t7;
      if (freeze_start) begin
        user_q[0] <= `BCD_ZERO;
      end else if (transfer_en) begin
        // simultaneous copy of the whole set avoids a torn read
        user_q[0] <= t0;
        user_q[1] <= t1;
        user_q[2] <= t2;
        user_q[3] <= t3;
        user_q[4] <= t4;
        user_q[5] <= t5;
        user_q[6] <= t6;
        user_q[7] <= t7;
      end
    end
  end

  // ==========================================================
  // tamper flags: hardware set wins over disarm clear
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tamper_event_flag_q <= 2'h0;
    end else begin
      // later events only re-set a flag; the frozen time stays
      tamper_event_flag_q[1] <= tamper_hit[1] | (tamper_event_flag_q[1] & ~arm_clear1);
      tamper_event_flag_q[0] <= tamper_hit[0] | (tamper_event_flag_q[0] & ~arm_clear2);
    end
  end

  // ==========================================================
  // control, halt and tamper configuration registers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_q <= 8'h00;
      halt_reg_q <= 8'h00;
      tamper1_q <= 8'h00;
      tamper2_q <= 8'h00;
    end else begin
      if (wr_pend_q && wr_idx_q == `IDX_CONTROL) begin
        control_q <= wbyte;
      end
      if (wr_pend_q && wr_idx_q == `IDX_HALT) begin
        halt_reg_q <= wbyte;
      end
      // power-down set beats a simultaneous software clear
      if (ht_set) begin
        halt_reg_q[`BIT_HALT_UPDATE] <= 1'b1;
      end
      if (wr_pend_q && wr_idx_q == `IDX_TAMPER1) begin
        tamper1_q <= wbyte;
      end
      if (wr_pend_q && wr_idx_q == `IDX_TAMPER2) begin
        tamper2_q <= wbyte;
      end
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait states, read data registered
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (addr_is_clock) begin
      rd_byte = user_q[addr_idx[2:0]];
    end else begin
      case (addr_idx)
        `IDX_CONTROL: rd_byte = control_q;
        `IDX_HALT: rd_byte = halt_reg_q;
        `IDX_FLAGS: begin
          rd_byte[`BIT_FLAG_TB1] = tamper_event_flag_q[1];
          rd_byte[`BIT_FLAG_TB2] = tamper_event_flag_q[0];
        end
        `IDX_TAMPER1: rd_byte = tamper1_q;
        `IDX_TAMPER2: rd_byte = tamper2_q;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // address phase capture and clock-access tracking
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 6'h00;
      clock_access_q <= 1'b0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      if (addr_phase) begin
        wr_pend_q <= hwrite;
        wr_idx_q <= addr_idx;
        clock_access_q <= addr_is_clock;
        hrdata <= hwrite ? 32'h0 : {24'h0, rd_byte};
      end else if (hready) begin
        // idle bus acts as the stop that lets updates resume
        wr_pend_q <= 1'b0;
        clock_access_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status outputs
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      time_frozen <= 1'b0;
      osc_running <= 1'b0;
    end else begin
      time_frozen <= ht_q | tamper_freeze;
      osc_running <= ~osc_halt;
    end
  end

endmodule // rtc_user_timestamp

// File: test/ts_props.sv
`timescale 1ns/1ps
`include "rtc_consts.vh"
// ==========================================================
// port watcher
module ts_props #(
  parameter TICK_CYCLES = 4
) (
  input wire clock,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [1:0] tamper_in,
  input wire power_down_in,
  input wire backup_in,
  input wire time_frozen,
  input wire osc_running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire acc = hsel && hready && htrans[1];
  wire rd_acc = acc && !hwrite;
  wire [5:0] idx = haddr[7:2];
  reg [3:0] quiet_q;
  reg [3:0] wr_gap_q;
  // ages since a freeze cause or a write; saturate so they never wrap
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= 4'hF;
      wr_gap_q <= 4'hF;
    end else begin
      quiet_q <= (|tamper_in || power_down_in || (acc && hwrite)) ? 4'h0
        : quiet_q + {3'h0, quiet_q != 4'hF};
      wr_gap_q <= (acc && hwrite) ? 4'h0 : wr_gap_q + {3'h0, wr_gap_q != 4'hF};
    end
  end
  property p_bus_ok; hreadyout && (hresp == `HRESP_OKAY); endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  property p_sub_bcd; rd_acc && idx == `IDX_SUBSEC |=> hrdata[7:4] <= 4'h9 && hrdata[3:0] <= 4'h9;
  endproperty
  a_sub_bcd: assert property (p_sub_bcd) else $error("sub-second not bcd");
  property p_sec_bcd; rd_acc && idx == `IDX_SEC |=> hrdata[6:4] <= 3'h5 && hrdata[3:0] <= 4'h9;
  endproperty
  a_sec_bcd: assert property (p_sec_bcd) else $error("seconds not bcd");
  property p_dow; rd_acc && idx == `IDX_DAY |=> hrdata[2:0] != 3'h0; endproperty
  a_dow: assert property (p_dow) else $error("weekday out of range");
  property p_frz_sub; rd_acc && time_frozen && idx == `IDX_SUBSEC |=> hrdata[7:0] == 8'h00;
  endproperty
  a_frz_sub: assert property (p_frz_sub) else $error("frozen sub-second not zero");
  property p_frz_rise; $rose(time_frozen) |-> quiet_q < 4'hA; endproperty
  a_frz_rise: assert property (p_frz_rise) else $error("freeze without cause");
  property p_frz_fall; $fell(time_frozen) |-> wr_gap_q < 4'h6; endproperty
  a_frz_fall: assert property (p_frz_fall) else $error("freeze ended without write");
  property p_osc_fall; $fell(osc_running) |-> wr_gap_q < 4'h6; endproperty
  a_osc_fall: assert property (p_osc_fall) else $error("oscillator stopped unasked");
  c_frz_read: cover property (rd_acc && time_frozen && idx == `IDX_SUBSEC);
  c_frz_rise: cover property ($rose(time_frozen));
  c_osc_stop: cover property ($fell(osc_running));
endmodule // ts_props

bind rtc_user_timestamp ts_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (
  .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .tamper_in(tamper_in),
  .power_down_in(power_down_in), .backup_in(backup_in), .time_frozen(time_frozen),
  .osc_running(osc_running));

// File: test/bus_host.sv
`timescale 1ns/1ps
// ==========================================================
// host master, single word transfers
module bus_host (
  input wire clock,
  input wire hready,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
  end
  // waits are open ended; only the bench watchdog cuts them short
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, idx, 2'b00};
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'b00;
    // a read leaves the data lines churning, not holding stale data
    hwdata <= wr ? {24'h000000, wd} : ~hwdata;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule // bus_host

// File: test/tb_top.sv
`timescale 1ns/1ps
`include "rtc_consts.vh"
module tb_top;
  localparam TICK = 4;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg [1:0] tamper_in = 2'b00;
  reg power_down_in = 1'b0;
  reg backup_in = 1'b0;
  wire hsel, hwrite, hready, hresp, time_frozen, osc_running;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  logic [31:0] rd;
  logic [31:0] keep;
  integer bad_count = 0;
  integer checked = 0;
  always #2 clock = ~clock;
  rtc_user_timestamp #(.TICK_CYCLES(TICK)) dut_u (
    .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .tamper_in(tamper_in),
    .power_down_in(power_down_in), .backup_in(backup_in), .time_frozen(time_frozen),
    .osc_running(osc_running));
  bus_host host_u (.clock(clock), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    host_u.xfer(1'b1, idx, d, rd);
  endtask
  task automatic rdr(input logic [5:0] idx);
    host_u.xfer(1'b0, idx, 8'h00, rd);
  endtask
  // status lags its cause by one registered edge; sample away from the edge
  task automatic frz(input logic e);
    @(posedge clock);
    @(negedge clock);
    chk("time_frozen", {31'h0, e}, {31'h0, time_frozen});
  endtask
  // held long enough to pass the input synchronisers
  task automatic pulse(input logic [1:0] t, input logic p);
    @(posedge clock);
    tamper_in <= t;
    power_down_in <= p;
    repeat (4) @(posedge clock);
    tamper_in <= 2'b00;
    power_down_in <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  // ==========================================================
  // scenarios
  task automatic run_dates;
    logic [5:0] i;
    for (i = 6'h04; i < 6'h08; i = i + 6'h01) begin
      rdr(i);
      chk("date byte", (i == 6'h07) ? 32'h0 : 32'h1, rd);
    end
    rdr(6'h10);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(`IDX_CONTROL, 8'h5A);
    rdr(`IDX_CONTROL);
    chk("control", 32'h5A, rd);
  endtask
  task automatic run_stopped;
    wr(`IDX_SEC, 8'hB0);
    frz(1'b0);
    chk("osc", 32'h0, {31'h0, osc_running});
    wr(`IDX_SUBSEC, 8'h55);
    rdr(`IDX_SUBSEC);
    chk("subsec", 32'h0, rd);
    wr(`IDX_HOUR, 8'hA3);
    wr(`IDX_DAY, 8'h45);
    repeat (50) @(posedge clock);
    rdr(`IDX_HOUR);
    chk("hour", 32'hA3, rd);
    rdr(`IDX_DAY);
    chk("day", 32'h5, rd & 32'h7);
    chk("day byte", 32'h45, rd);
    rdr(`IDX_SEC);
    chk("held sec", 32'hB0, rd);
    wr(`IDX_SEC, 8'h30);
    repeat (200) @(posedge clock);
    chk("osc", 32'h1, {31'h0, osc_running});
    wr(`IDX_MIN, 8'h00);
    rdr(`IDX_SUBSEC);
    chk("subsec reset", 32'h0, rd);
    repeat (990) @(posedge clock);
    rdr(`IDX_SEC);
    chk("sec", 32'h32, rd);
  endtask
  task automatic run_tamper;
    wr(`IDX_TAMPER1, 8'h80);
    pulse(2'b10, 1'b0);
    frz(1'b1);
    wr(`IDX_FLAGS, 8'h01);
    rdr(`IDX_FLAGS);
    chk("flags", 32'h2, rd);
    rdr(`IDX_SUBSEC);
    chk("subsec", 32'h0, rd);
    rdr(`IDX_SEC);
    keep = rd;
    repeat (500) @(posedge clock);
    pulse(2'b11, 1'b0);
    rdr(`IDX_FLAGS);
    chk("flags", 32'h2, rd);
    rdr(`IDX_SEC);
    chk("stamp", keep, rd);
    wr(`IDX_TAMPER1, 8'h00);
    frz(1'b0);
    rdr(`IDX_FLAGS);
    chk("flags", 32'h0, rd);
    rdr(`IDX_SEC);
    chk("sec moved", 32'h1, {31'h0, rd !== keep});
  endtask
  task automatic run_power;
    wr(`IDX_TAMPER2, 8'h80);
    pulse(2'b00, 1'b1);
    frz(1'b0);
    rdr(`IDX_HALT);
    chk("halt", 32'h0, rd & 32'h40);
    wr(`IDX_TAMPER2, 8'h00);
    // host reads the seconds ahead of the power-down; the value is not kept
    rdr(`IDX_SEC);
    pulse(2'b00, 1'b1);
    frz(1'b1);
    rdr(`IDX_HALT);
    chk("halt", 32'h40, rd & 32'h40);
    rdr(`IDX_SUBSEC);
    chk("subsec", 32'h0, rd);
    rdr(`IDX_SEC);
    keep = rd;
    repeat (500) @(posedge clock);
    rdr(`IDX_SEC);
    chk("halted sec", keep, rd);
    wr(`IDX_HALT, 8'h00);
    frz(1'b0);
    rdr(`IDX_SEC);
    chk("sec moved", 32'h1, {31'h0, rd !== keep});
  endtask
  task automatic run_backup;
    @(posedge clock);
    backup_in <= 1'b1;
    repeat (4) @(posedge clock);
    rdr(`IDX_SEC);
    keep = rd;
    repeat (500) @(posedge clock);
    rdr(`IDX_SEC);
    chk("backup sec", keep, rd);
    backup_in <= 1'b0;
    repeat (4) @(posedge clock);
    rdr(`IDX_SEC);
    chk("sec moved", 32'h1, {31'h0, rd !== keep});
  endtask
  task complete_run;
    $display("mismatches %0d, checks %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    run_dates();
    run_stopped();
    run_tamper();
    run_power();
    run_backup();
    complete_run();
  end
  // watchdog, several times the expected run length
  initial begin
    #100000;
    bad_count = bad_count + 1;
    complete_run();
  end
endmodule // tb_top
